// [hdl/psr_pkg.sv]
// Purpose: Shared constants and types of the press stroke rearm permit block.
// Assumes: 40 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: All times are kept in their printed unit and turned into counts here.
package psr_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DEF = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_CNT_W = 16;

    localparam int REARM_MIN_SHORT_MS = 100;
    localparam int REARM_MIN_LONG_MS = 350;
    localparam int REARM_MAX_S = 30;
    localparam int REARM_CNT_W = 15;
    localparam logic [REARM_CNT_W-1:0] REARM_MIN_SHORT_TICKS = REARM_CNT_W'(REARM_MIN_SHORT_MS);
    localparam logic [REARM_CNT_W-1:0] REARM_MIN_LONG_TICKS = REARM_CNT_W'(REARM_MIN_LONG_MS);
    localparam logic [REARM_CNT_W-1:0] REARM_MAX_TICKS = REARM_CNT_W'(REARM_MAX_S * 1000);

    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [2:0] MODE_NEVER = 3'h1;
    localparam logic [2:0] MODE_ALWAYS = 3'h2;
    localparam logic [2:0] MODE_RUN_PRIM_SAFE = 3'h3;
    localparam logic [2:0] MODE_TDC_PRIM_SAFE = 3'h4;
    localparam logic [2:0] MODE_PRIM_SAFE = 3'h5;

    // Control word as it sits in the low bits of the control register.
    typedef struct packed {
        logic upstroke_en;
        logic safety_en;
        logic start_en;
        logic long_pulse;
        logic [2:0] rearm_mode;
    } psr_ctrl_t;

    localparam int CTRL_W = 7;
    localparam psr_ctrl_t CTRL_RESET = '{upstroke_en: 1'b0, safety_en: 1'b0, start_en: 1'b0,
                                         long_pulse: 1'b0, rearm_mode: MODE_ALWAYS};
    localparam int STATUS_W = 9;
endpackage

// [hdl/psr_rearm_pulse.sv]
// Purpose: Judges each high pulse on the synchronised rearm input.
// Assumes: rearm_level is already in the aclk domain; ms_tick is one cycle per millisecond.
// Notes: Width resolution is one tick, so a pulse may read up to one millisecond short.
`timescale 1ns/1ps
module psr_rearm_pulse
    import psr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic ms_tick,
    input wire logic rearm_level,
    input wire logic long_min,
    output logic rearm_ok
);
    logic level_q;
    logic [REARM_CNT_W-1:0] high_ms;

    wire fall = level_q & ~rearm_level;
    wire [REARM_CNT_W-1:0] min_ticks = long_min ? REARM_MIN_LONG_TICKS : REARM_MIN_SHORT_TICKS;
    // Counting stops one past the ceiling so an overlong press can never wrap back into range.
    wire saturated = (high_ms > REARM_MAX_TICKS);
    wire in_window = (high_ms >= min_ticks) & ~saturated;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
            high_ms <= '0;
            rearm_ok <= 1'b0;
        end else if (ce) begin
            level_q <= rearm_level;
            rearm_ok <= fall & in_window;
            if (!rearm_level) begin
                high_ms <= '0;
            end else if (ms_tick && !saturated) begin
                high_ms <= high_ms + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_OK_NEEDS_MIN: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(rearm_ok) |-> $past(high_ms) >= $past(min_ticks) && $past(level_q) && !$past(rearm_level))
        else $error("rearm accepted without a full low-high-low of minimum width");
    AST_LONG_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && saturated && fall |=> !rearm_ok)
        else $error("rearm pulse over the ceiling was accepted");
    COV_VALID_PULSE: cover property (@(posedge aclk) disable iff (!aresetn) rearm_ok);
endmodule

// [hdl/psr_press_permit.sv]
// Purpose: Single-stroke press permit with restart interlock and AXI4-Lite control.
// Assumes: Permit and pushbutton inputs are asynchronous pins; one 40 MHz clock.
// Notes: Upstroke muting is a plain bypass here; its time limit lives outside this block.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Rearm condition takes values one to five.
// - Setting one: restart needs no rearm.
// - Settings two to five: permit returns after rearm; three to five demand it only for their own stop causes.
// - Rearm is low-high-low, high at least minimum.
// - Too short or over thirty seconds ignored.
// - Permit rises on run edge when all clear.
// - Pending is high while awaiting rearm.
// - Pending clears on rearm; never with permit.
// - Primary permit low drops the permit.
// - Top dead centre rising edge ends stroke.
// - Unmuted safety loss drops permit, demands rearm.
// - Start permit unwatched while permit is high.
module psr_press_permit
    import psr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic run_cmd,
    input wire logic primary_permit,
    input wire logic start_permit,
    input wire logic safety_permit,
    input wire logic tdc,
    input wire logic upstroke,
    input wire logic rearm_btn,
    output logic press_permit,
    output logic rearm_pending
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage one feeds only stage two.
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic run_q;
    logic tdc_q;

    wire [6:0] pins = {rearm_btn, upstroke, tdc, safety_permit, start_permit, primary_permit, run_cmd};
    wire run_s = pin_sync[0];
    wire prim_s = pin_sync[1];
    wire start_s = pin_sync[2];
    wire safety_s = pin_sync[3];
    wire tdc_s = pin_sync[4];
    wire ups_s = pin_sync[5];
    wire rearm_s = pin_sync[6];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
            run_q <= 1'b0;
            tdc_q <= 1'b0;
        end else if (ce) begin
            pin_meta <= pins;
            pin_sync <= pin_meta;
            run_q <= run_s;
            tdc_q <= tdc_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick.
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic ms_tick;
    wire tick_wrap = (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= '0;
            ms_tick <= 1'b0;
        end else if (ce) begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
            ms_tick <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    psr_ctrl_t ctrl;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire [ADDR_W-1:0] cur_waddr = aw_hs ? s_axi_awaddr : wr_addr;
    wire [31:0] cur_wdata = w_hs ? s_axi_wdata : wr_data;
    wire cur_lane0 = w_hs ? s_axi_wstrb[0] : wr_lane0;
    wire aw_have = ~s_axi_awready | aw_hs;
    wire w_have = ~s_axi_wready | w_hs;
    wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
    wire wr_mapped = (cur_waddr == CTRL_OFFSET) | (cur_waddr == STATUS_OFFSET);
    wire [2:0] new_mode = cur_wdata[2:0];
    // Out-of-range modes are refused so the interlock can never sit in an undefined setting.
    wire mode_legal = (new_mode >= MODE_NEVER) & (new_mode <= MODE_PRIM_SAFE);
    wire ctrl_wr = wr_fire & (cur_waddr == CTRL_OFFSET) & cur_lane0;
    wire [STATUS_W-1:0] status = {pin_sync, rearm_pending, press_permit};
    wire [31:0] rd_mux = (s_axi_araddr == CTRL_OFFSET) ? {25'h0, ctrl} :
                         (s_axi_araddr == STATUS_OFFSET) ? {23'h0, status} : 32'h0;
    wire rd_mapped = (s_axi_araddr == CTRL_OFFSET) | (s_axi_araddr == STATUS_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            wr_addr <= '0;
            wr_data <= '0;
            wr_lane0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) begin
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                wr_data <= s_axi_wdata;
                wr_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (ctrl_wr) begin
                ctrl <= '{upstroke_en: cur_wdata[6], safety_en: cur_wdata[5], start_en: cur_wdata[4],
                          long_pulse: cur_wdata[3], rearm_mode: mode_legal ? new_mode : ctrl.rearm_mode};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Permit and interlock.
    logic rearm_ok;

    psr_rearm_pulse u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .ms_tick(ms_tick),
        .rearm_level(rearm_s),
        .long_min(ctrl.long_pulse),
        .rearm_ok(rearm_ok)
    );

    wire run_rise = run_s & ~run_q;
    wire tdc_rise = tdc_s & ~tdc_q;
    wire muted = ctrl.upstroke_en & prim_s & ups_s & press_permit;
    wire safety_ok = ~ctrl.safety_en | safety_s | muted;
    wire start_ok = ~ctrl.start_en | start_s;
    // The start permit is absent from the drop terms, so it only gates the grant.
    wire drop = ~prim_s | tdc_rise | ~safety_ok | ~run_s;
    wire grant = ~rearm_pending & prim_s & start_ok & safety_ok & run_rise & ~tdc_rise;
    wire next_permit = press_permit ? ~drop : grant;
    wire mode_never = (ctrl.rearm_mode == MODE_NEVER);
    wire demand_cond = (ctrl.rearm_mode == MODE_ALWAYS) |
                       ((ctrl.rearm_mode == MODE_RUN_PRIM_SAFE) & (~run_s | ~prim_s | ~safety_ok)) |
                       ((ctrl.rearm_mode == MODE_TDC_PRIM_SAFE) & (tdc_s | ~prim_s | ~safety_ok)) |
                       ((ctrl.rearm_mode == MODE_PRIM_SAFE) & (~prim_s | ~safety_ok));
    wire demand = press_permit & drop & demand_cond;
    // A demand in the same cycle as an accepted rearm wins, so a fresh stop is never lost.
    wire next_pending = mode_never ? 1'b0 : (demand | (rearm_pending & ~rearm_ok));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            press_permit <= 1'b0;
            rearm_pending <= 1'b1;
        end else if (ce) begin
            press_permit <= next_permit & ~next_pending;
            rearm_pending <= next_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_NEVER_BOTH: assert property (@(posedge aclk) disable iff (!aresetn)
        !(press_permit && rearm_pending))
        else $error("permit high while rearm is pending");
    AST_PRIMARY_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !prim_s |=> !press_permit)
        else $error("permit stayed high with primary permit low");
    AST_TDC_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && tdc_s && !tdc_q |=> !press_permit)
        else $error("permit survived top dead centre edge");
    AST_SAFETY_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ctrl.safety_en && !safety_s && !muted |=> !press_permit)
        else $error("permit stayed high on unmuted safety loss");
    AST_GRANT_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(press_permit) |-> $past(run_rise) && $past(prim_s) && $past(start_ok) && !$past(rearm_pending))
        else $error("permit rose without its enabling conditions");
    AST_MODE_NEVER: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && mode_never |=> !rearm_pending)
        else $error("rearm pending in setting one");
    AST_CLEAR_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(rearm_pending) |-> $past(rearm_ok) || $past(mode_never))
        else $error("pending cleared without a valid rearm");
    AST_DEMAND: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && press_permit && !prim_s && !mode_never |=> rearm_pending)
        else $error("stop on primary loss did not demand rearm");
    AST_MODE_LEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl.rearm_mode >= MODE_NEVER && ctrl.rearm_mode <= MODE_PRIM_SAFE)
        else $error("rearm setting outside one to five");
    AST_RESET_CLEAR: assert property (@(posedge aclk)
        !aresetn |=> !press_permit && rearm_pending && !s_axi_bvalid && !s_axi_rvalid)
        else $error("reset did not clear the permit state");
    COV_STROKE: cover property (@(posedge aclk) disable iff (!aresetn) press_permit ##[1:1000] tdc_rise);
    COV_REARM: cover property (@(posedge aclk) disable iff (!aresetn) $fell(rearm_pending));
    COV_MUTED: cover property (@(posedge aclk) disable iff (!aresetn) press_permit && muted && !safety_s);
endmodule

// [testbench/psr_far_side.sv]
// Purpose: Operator pushbutton model that gives one rearm press of a chosen length.
// Assumes: TICK_CYCLES matches the design instance; one press at a time.
// Notes: The button rests low, so the press is always a low-high-low sequence.
`timescale 1ns/1ps
module psr_far_side
#(
    parameter int TICK_CYCLES = 4
)
(
    input wire logic aclk,
    input wire logic go,
    input wire logic [15:0] high_ms,
    output logic rearm_btn,
    output logic busy
);
    int cnt = 0;
    initial rearm_btn = 1'b0;
    assign busy = (cnt != 0);
    always @(posedge aclk) begin
        if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                rearm_btn <= 1'b0;
            end
        end else if (go) begin
            cnt <= int'(high_ms) * TICK_CYCLES;
            rearm_btn <= 1'b1;
        end
    end
endmodule

// [testbench/psr_press_permit_bench.sv]
// Purpose: Self-checking bench for the press permit block over AXI4-Lite and pins.
// Assumes: TICK_CYCLES shortened to 2, so one millisecond is two clocks.
// Assumes: The short tick keeps a press beyond the thirty second ceiling inside the run limit.
// Notes: Pulses are given two ticks of margin because width is read to one tick.
`timescale 1ns/1ps
module psr_press_permit_bench;
    import psr_pkg::*;
    localparam int TC = 2;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic run_cmd = 1'b0, primary_permit = 1'b0, start_permit = 1'b0, safety_permit = 1'b0;
    logic tdc = 1'b0, upstroke = 1'b0, rearm_btn, press_permit, rearm_pending, go = 1'b0, busy;
    logic [15:0] pulse_ms = 16'h0;
    logic [31:0] d;
    int errors = 0, n_tests = 0;
    always #12.5 aclk = ~aclk;
    psr_press_permit #(.TICK_CYCLES(TC)) DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_cmd, .primary_permit, .start_permit,
        .safety_permit, .tdc, .upstroke, .rearm_btn, .press_permit, .rearm_pending);
    psr_far_side #(.TICK_CYCLES(TC)) far (.aclk, .go, .high_ms(pulse_ms), .rearm_btn, .busy);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Handshakes are sampled at the falling edge, where the answer has settled.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        logic ar, rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!rv);
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse(input logic [15:0] ms);
        pulse_ms <= ms;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        while (busy) @(posedge aclk);
        wt(12);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wt(12);
        aresetn <= 1'b1;
        primary_permit <= 1'b1;
        wt(1);
        check(press_permit, 0);
        check(rearm_pending, 1);
        rd(CTRL_OFFSET);
        check(d, 32'h2);
        rd(4'h8);
        check(r, RESP_SLVERR);
        // Setting one is read back later, because writing it here would clear the interlock left by reset.
        for (int m = 2; m <= 5; m++) begin
            wr(CTRL_OFFSET, m);
            check(r, RESP_OKAY);
            rd(CTRL_OFFSET);
            check(d, m);
        end
        wr(CTRL_OFFSET, 32'h0);
        rd(CTRL_OFFSET);
        check(d, 32'h5);
        wr(CTRL_OFFSET, 32'h2);
        run_cmd <= 1'b1;
        wt(6);
        check(press_permit, 0);
        run_cmd <= 1'b0;
        pulse(98);
        check(rearm_pending, 1);
        pulse(102);
        check(rearm_pending, 0);
        run_cmd <= 1'b1;
        wt(6);
        check(press_permit, 1);
        rd(STATUS_OFFSET);
        check(d, 32'h0000000D);
        tdc <= 1'b1;
        wt(6);
        check(press_permit, 0);
        check(rearm_pending, 1);
        tdc <= 1'b0;
        run_cmd <= 1'b0;
        wr(CTRL_OFFSET, 32'h0A);
        pulse(102);
        check(rearm_pending, 1);
        pulse(352);
        check(rearm_pending, 0);
        wr(CTRL_OFFSET, 32'h11);
        rd(CTRL_OFFSET);
        check(d, 32'h11);
        wt(6);
        run_cmd <= 1'b1;
        wt(6);
        check(press_permit, 0);
        run_cmd <= 1'b0;
        start_permit <= 1'b1;
        wt(6);
        run_cmd <= 1'b1;
        wt(6);
        check(press_permit, 1);
        start_permit <= 1'b0;
        wt(6);
        check(press_permit, 1);
        primary_permit <= 1'b0;
        wt(6);
        check(press_permit, 0);
        check(rearm_pending, 0);
        primary_permit <= 1'b1;
        start_permit <= 1'b1;
        run_cmd <= 1'b0;
        safety_permit <= 1'b1;
        wt(6);
        run_cmd <= 1'b1;
        wt(6);
        check(press_permit, 1);
        wr(CTRL_OFFSET, 32'h65);
        upstroke <= 1'b1;
        safety_permit <= 1'b0;
        wt(6);
        check(press_permit, 1);
        upstroke <= 1'b0;
        wt(6);
        check(press_permit, 0);
        check(rearm_pending, 1);
        pulse(30002);
        check(rearm_pending, 1);
        pulse(102);
        check(rearm_pending, 0);
        close_out();
    end
    initial begin
        wt(80000);
        errors++;
        close_out();
    end
endmodule
